// ### include/sct_cfg.svh
/*
  constants of the slow counter with tick timer: register indices, field positions,
  reset values and sync counts; assumes it is included by bare name, once per unit
*/
`ifndef SCT_CFG_SVH
`define SCT_CFG_SVH
// register indices, byte address is four times the index
`define SCT_IDX_CTRL 5'h00
`define SCT_IDX_STAT 5'h01
`define SCT_IDX_IRQEN 5'h02
`define SCT_IDX_PEND 5'h03
`define SCT_IDX_TEMP 5'h04
`define SCT_IDX_HALT 5'h05
`define SCT_IDX_CSEL 5'h07
`define SCT_IDX_CNTL 5'h08
`define SCT_IDX_CNTH 5'h09
`define SCT_IDX_TOPL 5'h0A
`define SCT_IDX_TOPH 5'h0B
`define SCT_IDX_CMPL 5'h0C
`define SCT_IDX_CMPH 5'h0D
`define SCT_IDX_TCTRL 5'h10
`define SCT_IDX_TSTAT 5'h11
`define SCT_IDX_TIRQEN 5'h12
`define SCT_IDX_TPEND 5'h13
`define SCT_IDX_THALT 5'h15
// field positions
`define SCT_ON_BIT 0
`define SCT_KEEP_BIT 7
`define SCT_FLD_HI 6
`define SCT_FLD_LO 3
`define SCT_WRAP_BIT 0
`define SCT_MATCH_BIT 1
// writable bit masks
`define SCT_CTRL_MASK 8'hF9
`define SCT_TCTRL_MASK 8'h79
`define SCT_CSEL_MASK 8'h03
`define SCT_IRQ2_MASK 8'h03
`define SCT_BIT0_MASK 8'h01
// reset values
`define SCT_RST8 8'h00
`define SCT_RST16 16'h0000
`define SCT_TOP_RST 16'hFFFF
`define SCT_RST15 15'h0000
// busy lasts this many slow clock edges before a write is applied
`define SCT_SYNC_TICKS 2'h2
`define SCT_SYNC_LAST 2'h1
`define SCT_SYNC_IDLE 2'h0
// busy slots
`define SCT_NBUSY 5
`define SCT_B_CTRL 0
`define SCT_B_CNT 1
`define SCT_B_TOP 2
`define SCT_B_CMP 3
`define SCT_B_TCTRL 4
// tick timer
`define SCT_EVT_TOP 4'hD
`define SCT_PER_OFF 4'h0
`define SCT_PER_RSV 4'hF
`define SCT_ONE4 4'h1
`endif

// ### include/sct_pkg.sv
/*
  types shared by the slow counter with tick timer; assumes nothing beyond the cfg header
*/
package sct_pkg;
  // event outputs toward the event router, each a one-cycle pulse
  typedef struct packed {
    logic wrap;
    logic match;
    logic [7:0] tick;
  } sct_evt_t;
endpackage

// ### verilog/sct_top.sv
/*
  slow counter with compare and wrap events, plus tick timer with eight periodic events,
  behind an avalon-mm slave with waitrequest.
  assumes slow_clk is a pin slower than a quarter of ref_clk, and the sleep and halt
  inputs are asynchronous levels from the system.
*/
// Design decision made here: the Avalon-MM register port.
// How it works
// - tick timer runs while tick_on is one, stops when written zero
// - enabled counter emits wrap event after reaching top and returning to zero
// - enabled counter emits match event when count equals match value
// - tick events 0..7 fire every 8192 down to 64 slow periods
// - two irq lines: counter one for wrap and match, tick one
// - tick irq fires each time the selected interval elapses
// - every condition sets its pending flag, enabled or not
// - irq high while enable and pending are both set, until cleared
// - sources switched only by their own enable bits
// - counter keeps counting in idle sleep
// - in standby counter runs only with standby_keepalive set
// - tick timer runs in every sleep mode
// - counting uses slow clock; writes apply after a crossing delay
// - status shows busy per match, top, count, control write in flight
// - tick status shows busy while tick control write in flight
// - counter control resets zero; keepalive bit 7, divider 6:3, on bit 0
// - writing one clears a pending flag, zero leaves it
// - count event at top resets count to zero and signals wrap
// - halt_override zero stops block during debug halt, one keeps it
`include "sct_cfg.svh"
`timescale 1ns/1ns
module sct_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave, word address is the register index
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // asynchronous pins
  input wire logic slow_clk,
  input wire logic sleep_standby,
  input wire logic debug_halt,
  // interrupt and event outputs
  output logic counter_irq,
  output logic tick_irq,
  output sct_pkg::sct_evt_t events
);

  // divider mask of k low ones, shared by prescaler and tick chain
  function automatic logic [14:0] sct_mask(input logic [3:0] k);
    logic [15:0] m;
    m = (16'h0001 << k) - 16'h0001;
    return m[14:0];
  endfunction

  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [7:0] ctrl_ff, ctrl_act_ff, tctrl_ff, tctrl_act_ff, temp_ff, csel_ff;
  logic [1:0] irqen_ff, pend_ff;
  logic tirqen_ff, tpend_ff, halt_ff, thalt_ff;
  logic [15:0] cnt_wr_ff, top_ff, top_act_ff, cmp_ff, cmp_act_ff, cnt_ff;
  logic [1:0] bcnt_ff [`SCT_NBUSY];
  logic [14:0] presc_ff, div_ff;
  logic [2:0] clk_sync_ff;
  logic [1:0] stby_sync_ff, halt_sync_ff;
  logic cnt_irq_ff, tick_irq_ff;
  sct_pkg::sct_evt_t evt_ff;

  // bus handshake: one wait cycle, then the request is served
  wire req = avs_read | avs_write;
  wire acc = req & ~ack_ff;
  wire wr = avs_write & ack_ff;
  wire [7:0] wd = avs_writedata[7:0];
  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= acc;
    end
  end

  // pins pass two flops; third slow_clk stage only feeds the edge detector
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_sync_ff <= 3'h0;
      stby_sync_ff <= 2'h0;
      halt_sync_ff <= 2'h0;
    end
    else
    begin
      clk_sync_ff <= {clk_sync_ff[1:0], slow_clk};
      stby_sync_ff <= {stby_sync_ff[0], sleep_standby};
      halt_sync_ff <= {halt_sync_ff[0], debug_halt};
    end
  end

  // slow domain step: one ref_clk cycle per rising slow_clk edge
  wire slow_edge = clk_sync_ff[1] & ~clk_sync_ff[2];
  wire stby_s = stby_sync_ff[1];
  wire halt_s = halt_sync_ff[1];

  // address decode of writes that commit
  wire wr_ctrl = wr & (avs_address == `SCT_IDX_CTRL);
  wire wr_irqen = wr & (avs_address == `SCT_IDX_IRQEN);
  wire wr_pend = wr & (avs_address == `SCT_IDX_PEND);
  wire wr_temp = wr & (avs_address == `SCT_IDX_TEMP);
  wire wr_halt = wr & (avs_address == `SCT_IDX_HALT);
  wire wr_csel = wr & (avs_address == `SCT_IDX_CSEL);
  wire wr_low = wr & ((avs_address == `SCT_IDX_CNTL) | (avs_address == `SCT_IDX_TOPL)
                | (avs_address == `SCT_IDX_CMPL));
  wire wr_cnth = wr & (avs_address == `SCT_IDX_CNTH);
  wire wr_toph = wr & (avs_address == `SCT_IDX_TOPH);
  wire wr_cmph = wr & (avs_address == `SCT_IDX_CMPH);
  wire wr_tctrl = wr & (avs_address == `SCT_IDX_TCTRL);
  wire wr_tirqen = wr & (avs_address == `SCT_IDX_TIRQEN);
  wire wr_tpend = wr & (avs_address == `SCT_IDX_TPEND);
  wire wr_thalt = wr & (avs_address == `SCT_IDX_THALT);
  wire rd_cntl = acc & avs_read & (avs_address == `SCT_IDX_CNTL);
  wire [15:0] wd16 = {wd, temp_ff};

  // busy slots: start on write, count down on slow edges
  wire [`SCT_NBUSY-1:0] bstart = {wr_tctrl, wr_cmph, wr_toph, wr_cnth, wr_ctrl};
  wire [`SCT_NBUSY-1:0] busy;
  wire [`SCT_NBUSY-1:0] apply;
  genvar g;
  generate
    for (g = 0; g < `SCT_NBUSY; g++)
    begin : g_busy
      assign busy[g] = bcnt_ff[g] != `SCT_SYNC_IDLE;
      assign apply[g] = slow_edge & (bcnt_ff[g] == `SCT_SYNC_LAST);
      always_ff @(posedge ref_clk or negedge reset_n)
      begin
        if (!reset_n)
          bcnt_ff[g] <= `SCT_SYNC_IDLE;
        else if (bstart[g])
          bcnt_ff[g] <= `SCT_SYNC_TICKS;
        else if (slow_edge && busy[g])
          bcnt_ff[g] <= bcnt_ff[g] - `SCT_SYNC_LAST;
      end
    end
  endgenerate

  // bus-side registers; 16-bit ones go through the shared latch
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_ff <= `SCT_RST8;
      tctrl_ff <= `SCT_RST8;
      temp_ff <= `SCT_RST8;
      csel_ff <= `SCT_RST8;
      irqen_ff <= 2'h0;
      tirqen_ff <= 1'b0;
      halt_ff <= 1'b0;
      thalt_ff <= 1'b0;
      cnt_wr_ff <= `SCT_RST16;
      top_ff <= `SCT_TOP_RST;
      cmp_ff <= `SCT_RST16;
    end
    else
    begin
      if (wr_ctrl) ctrl_ff <= wd & `SCT_CTRL_MASK;
      if (wr_tctrl) tctrl_ff <= wd & `SCT_TCTRL_MASK;
      if (wr_csel) csel_ff <= wd & `SCT_CSEL_MASK;
      if (wr_irqen) irqen_ff <= wd[1:0];
      if (wr_tirqen) tirqen_ff <= wd[0];
      if (wr_halt) halt_ff <= wd[0];
      if (wr_thalt) thalt_ff <= wd[0];
      if (wr_temp || wr_low) temp_ff <= wd;
      else if (rd_cntl) temp_ff <= cnt_ff[15:8];
      if (wr_cnth) cnt_wr_ff <= wd16;
      if (wr_toph) top_ff <= wd16;
      if (wr_cmph) cmp_ff <= wd16;
    end
  end

  // slow-side copies take the value once the crossing finishes
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_act_ff <= `SCT_RST8;
      tctrl_act_ff <= `SCT_RST8;
      top_act_ff <= `SCT_TOP_RST;
      cmp_act_ff <= `SCT_RST16;
    end
    else
    begin
      if (apply[`SCT_B_CTRL]) ctrl_act_ff <= ctrl_ff;
      if (apply[`SCT_B_TCTRL]) tctrl_act_ff <= tctrl_ff;
      if (apply[`SCT_B_TOP]) top_act_ff <= top_ff;
      if (apply[`SCT_B_CMP]) cmp_act_ff <= cmp_ff;
    end
  end

  // counter run gate: idle sleep never stops it, standby needs keepalive
  wire cnt_on = ctrl_act_ff[`SCT_ON_BIT];
  wire standby_keepalive = ctrl_act_ff[`SCT_KEEP_BIT];
  wire run_cnt = cnt_on & ~(stby_s & ~standby_keepalive)
               & ~(halt_s & ~halt_ff);
  wire [3:0] psc_sel = ctrl_act_ff[`SCT_FLD_HI:`SCT_FLD_LO];
  wire [14:0] psc_m = sct_mask(psc_sel);
  wire cnt_evt = slow_edge & run_cnt & ((presc_ff & psc_m) == psc_m);
  wire at_top = cnt_ff == top_act_ff;
  wire wrap_evt = cnt_evt & at_top;
  wire match_evt = cnt_evt & (cnt_ff == cmp_act_ff);

  // prescaler and count
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      presc_ff <= `SCT_RST15;
      cnt_ff <= `SCT_RST16;
    end
    else
    begin
      if (!cnt_on) presc_ff <= `SCT_RST15;
      else if (slow_edge && run_cnt) presc_ff <= presc_ff + 15'h0001;
      if (apply[`SCT_B_CNT]) cnt_ff <= cnt_wr_ff;
      else if (cnt_evt) cnt_ff <= at_top ? `SCT_RST16 : cnt_ff + 16'h0001;
    end
  end

  // tick chain: one free divider, no standby gate at all
  wire tick_on = tctrl_act_ff[`SCT_ON_BIT];
  wire run_tick = tick_on & ~(halt_s & ~thalt_ff);
  wire tick_step = slow_edge & run_tick;
  wire [3:0] period = tctrl_act_ff[`SCT_FLD_HI:`SCT_FLD_LO];
  wire [14:0] per_m = sct_mask(4'(period + `SCT_ONE4));
  wire per_ok = (period != `SCT_PER_OFF) & (period != `SCT_PER_RSV);
  wire tick_evt = tick_step & per_ok & ((div_ff & per_m) == per_m);
  wire [7:0] tev;
  generate
    for (g = 0; g < 8; g++)
    begin : g_tev
      // event g every two to the (13 - g) slow periods
      assign tev[g] = tick_step & ((div_ff & sct_mask(4'(`SCT_EVT_TOP - g)))
                      == sct_mask(4'(`SCT_EVT_TOP - g)));
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      div_ff <= `SCT_RST15;
    else if (!tick_on)
      div_ff <= `SCT_RST15;
    else if (tick_step)
      div_ff <= div_ff + 15'h0001;
  end

  // pending flags: set wins over a write-one clear
  wire [1:0] cnt_set = {match_evt, wrap_evt};
  wire [1:0] cnt_clr = wr_pend ? wd[1:0] : 2'h0;
  wire t_clr = wr_tpend & wd[0];
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_ff <= 2'h0;
      tpend_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= (pend_ff & ~cnt_clr) | cnt_set;
      tpend_ff <= (tpend_ff & ~t_clr) | tick_evt;
    end
  end

  // counter request level, one wire shared by the flop and its check
  wire cnt_req = |(pend_ff & irqen_ff);

  // irq lines and event pulses from flops, one cycle after the cause
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_irq_ff <= 1'b0;
      tick_irq_ff <= 1'b0;
      evt_ff <= '0;
    end
    else
    begin
      cnt_irq_ff <= cnt_req;
      tick_irq_ff <= tpend_ff & tirqen_ff;
      evt_ff <= '{wrap: wrap_evt, match: match_evt, tick: tev};
    end
  end
  assign counter_irq = cnt_irq_ff;
  assign tick_irq = tick_irq_ff;
  assign events = evt_ff;

  // read mux; the high count byte comes from the latch filled by the low read
  logic [7:0] rmux;
  always_comb
  begin
    rmux = `SCT_RST8;
    unique case (avs_address)
      `SCT_IDX_CTRL: rmux = ctrl_ff;
      `SCT_IDX_STAT: rmux = {4'h0, busy[`SCT_B_CMP], busy[`SCT_B_TOP], busy[`SCT_B_CNT],
                             busy[`SCT_B_CTRL]};
      `SCT_IDX_IRQEN: rmux = {6'h00, irqen_ff};
      `SCT_IDX_PEND: rmux = {6'h00, pend_ff};
      `SCT_IDX_TEMP, `SCT_IDX_CNTH: rmux = temp_ff;
      `SCT_IDX_HALT: rmux = {7'h00, halt_ff};
      `SCT_IDX_CSEL: rmux = csel_ff;
      `SCT_IDX_CNTL: rmux = cnt_ff[7:0];
      `SCT_IDX_TOPL: rmux = top_ff[7:0];
      `SCT_IDX_TOPH: rmux = top_ff[15:8];
      `SCT_IDX_CMPL: rmux = cmp_ff[7:0];
      `SCT_IDX_CMPH: rmux = cmp_ff[15:8];
      `SCT_IDX_TCTRL: rmux = tctrl_ff;
      `SCT_IDX_TSTAT: rmux = {7'h00, busy[`SCT_B_TCTRL]};
      `SCT_IDX_TIRQEN: rmux = {7'h00, tirqen_ff};
      `SCT_IDX_TPEND: rmux = {7'h00, tpend_ff};
      `SCT_IDX_THALT: rmux = {7'h00, thalt_ff};
      default: rmux = `SCT_RST8;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_ff <= 32'h0000_0000;
    else if (acc && avs_read)
      rdata_ff <= {24'h00_0000, rmux};
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_tick_stops: assert property (!run_tick |=> events.tick == 8'h00)
    else $error("tick event while timer stopped");
  a_wrap_zero: assert property (wrap_evt |=> cnt_ff == `SCT_RST16 && events.wrap)
    else $error("wrap did not clear count");
  a_match_out: assert property (match_evt |=> events.match && pend_ff[1])
    else $error("match event or flag missing");
  a_tick_nest: assert property (events.tick[0] |-> events.tick[7])
    else $error("slow tick event without fast one");
  a_irq_level: assert property (##1 counter_irq == $past(cnt_req))
    else $error("counter irq not tracking enable and pending");
  a_standby_stop: assert property (stby_s && !standby_keepalive |-> !cnt_evt)
    else $error("counter counted in standby");
  a_ctrl_busy: assert property (wr_ctrl |=> busy[`SCT_B_CTRL] && !apply[`SCT_B_CTRL])
    else $error("control busy not raised");
  a_tick_busy: assert property (wr_tctrl |=> busy[`SCT_B_TCTRL] && !apply[`SCT_B_TCTRL])
    else $error("tick busy not raised");
  a_clear_pend: assert property (wr_pend && wd[0] && !wrap_evt |=> !pend_ff[0])
    else $error("write one did not clear pending");
  a_set_wins: assert property (wr_pend && wd[0] && wrap_evt |=> pend_ff[0])
    else $error("set lost against clear");
  a_wait_once: assert property (acc |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");

  c_wrap: cover property (events.wrap ##[1:1000] counter_irq);
  c_tick_irq: cover property (tick_evt ##2 tick_irq);
  c_busy_done: cover property (wr_ctrl ##[1:300] !busy[`SCT_B_CTRL]);

endmodule // sct_top

// ### bench/sct_evt_sink.sv
/*
  partner model of the event router: times the gaps between event pulses.
  assumes one-cycle event pulses sampled on ref_clk, reset_n asynchronous.
*/
`timescale 1ns/1ns
module sct_evt_sink (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // event pulses from the block
  input sct_pkg::sct_evt_t events,
  // last measured gaps, in ref cycles
  output logic [15:0] wrap_gap,
  output logic [15:0] match_wrap_gap,
  output logic [15:0] t7_gap,
  output logic [15:0] t6_gap
);
  logic [15:0] now_ff, wrap_ff, match_ff, t7_ff, t6_ff;
  // 16-bit stamps wrap, but every gap measured stays far below that
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {now_ff, wrap_ff, match_ff, t7_ff, t6_ff} <= 80'h0;
      {wrap_gap, match_wrap_gap, t7_gap, t6_gap} <= 64'h0;
    end
    else
    begin
      now_ff <= now_ff + 16'h0001;
      if (events.wrap)
      begin
        wrap_gap <= now_ff - wrap_ff;
        match_wrap_gap <= now_ff - match_ff;
        wrap_ff <= now_ff;
      end
      if (events.match)
        match_ff <= now_ff;
      if (events.tick[7])
      begin
        t7_gap <= now_ff - t7_ff;
        t7_ff <= now_ff;
      end
      if (events.tick[6])
      begin
        t6_gap <= now_ff - t6_ff;
        t6_ff <= now_ff;
      end
    end
  end
endmodule // sct_evt_sink

// ### bench/tb_top.sv
/*
  bench top: avalon transfer tasks, counter and tick scenarios, verdict.
  assumes sct_pkg, the cfg header and the event sink model are compiled with it.
*/
`include "sct_cfg.svh"
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic slow_clk, sleep_standby, debug_halt, counter_irq, tick_irq;
  sct_pkg::sct_evt_t events;
  logic [15:0] wrap_gap, match_wrap_gap, t7_gap, t6_gap;
  logic [7:0] q, r;
  int errors, checks;

  sct_top u_sct_top (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .slow_clk(slow_clk),
    .sleep_standby(sleep_standby), .debug_halt(debug_halt), .counter_irq(counter_irq),
    .tick_irq(tick_irq), .events(events));
  sct_evt_sink u_sct_evt_sink (.ref_clk(ref_clk), .reset_n(reset_n), .events(events),
    .wrap_gap(wrap_gap), .match_wrap_gap(match_wrap_gap), .t7_gap(t7_gap), .t6_gap(t6_gap));

  // 100 ns bus clock; slow pin is eight bus cycles, phase unrelated
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    slow_clk = 1'b0;
    #137;
    forever #400 slow_clk = ~slow_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic [4:0] a, input logic wr, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h000000, d};
    // no local limit: only the watchdog ends a wait that never finishes
    do
    begin
      @(posedge ref_clk);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk({24'h000000, q}, {24'h000000, e});
  endtask

  // poll a status register until no busy bit remains, bounded
  task automatic settle(input logic [4:0] a);
    int n;
    n = 0;
    do
    begin
      xfer(a, 1'b0, 8'h00);
      n++;
    end
    while (q !== 8'h00 && n < 40);
    chk({24'h000000, q}, 32'h00000000);
  endtask

  // two live count reads 40 cycles apart; e high means it stood still
  task automatic frozen(input logic e);
    repeat (4) @(posedge ref_clk);
    xfer(`SCT_IDX_CNTL, 1'b0, 8'h00);
    r = q;
    repeat (40) @(posedge ref_clk);
    xfer(`SCT_IDX_CNTL, 1'b0, 8'h00);
    chk({31'h0, r === q}, {31'h0, e});
  endtask

  task automatic close_out;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // watchdog, well past the roughly 4300 cycles the tests need
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    errors++;
    close_out();
  end

  initial
  begin
    {reset_n, avs_read, avs_write, sleep_standby, debug_halt} = 5'h00;
    avs_address = 5'h00;
    avs_writedata = 32'h00000000;
    errors = 0;
    checks = 0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    // reset values, unmapped place, stored source choice
    rd(`SCT_IDX_CTRL, 8'h00);
    rd(`SCT_IDX_TOPH, 8'hFF);
    rd(5'h06, 8'h00);
    wr(`SCT_IDX_CSEL, 8'h02);
    rd(`SCT_IDX_CSEL, 8'h02);
    // top 3, match 2, wrap irq only; top, match and control writes show their busy bits
    wr(`SCT_IDX_TOPL, 8'h03);
    wr(`SCT_IDX_TOPH, 8'h00);
    rd(`SCT_IDX_STAT, 8'h04);
    settle(`SCT_IDX_STAT);
    wr(`SCT_IDX_CMPL, 8'h02);
    wr(`SCT_IDX_CMPH, 8'h00);
    rd(`SCT_IDX_STAT, 8'h08);
    settle(`SCT_IDX_STAT);
    wr(`SCT_IDX_IRQEN, 8'h01);
    wr(`SCT_IDX_CTRL, 8'h01);
    rd(`SCT_IDX_STAT, 8'h01);
    settle(`SCT_IDX_STAT);
    repeat (200) @(posedge ref_clk);
    chk({16'h0, wrap_gap}, 32'h20);
    chk({16'h0, match_wrap_gap}, 32'h8);
    // divide by two doubles the wrap period
    wr(`SCT_IDX_CTRL, 8'h09);
    settle(`SCT_IDX_STAT);
    repeat (300) @(posedge ref_clk);
    chk({16'h0, wrap_gap}, 32'h40);
    // standby stops the counter unless kept alive
    sleep_standby <= 1'b1;
    frozen(1'b1);
    wr(`SCT_IDX_CTRL, 8'h89);
    settle(`SCT_IDX_STAT);
    frozen(1'b0);
    sleep_standby <= 1'b0;
    debug_halt <= 1'b1;
    frozen(1'b1);
    wr(`SCT_IDX_HALT, 8'h01);
    frozen(1'b0);
    debug_halt <= 1'b0;
    // stop, then pending flags and the shared counter request
    wr(`SCT_IDX_CTRL, 8'h00);
    settle(`SCT_IDX_STAT);
    rd(`SCT_IDX_PEND, 8'h03);
    chk({31'h0, counter_irq}, 32'h1);
    chk({31'h0, tick_irq}, 32'h0);
    wr(`SCT_IDX_PEND, 8'h02);
    rd(`SCT_IDX_PEND, 8'h01);
    wr(`SCT_IDX_PEND, 8'h01);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, counter_irq}, 32'h0);
    // count write through the latch while stopped, then paired read back
    wr(`SCT_IDX_CNTL, 8'h34);
    wr(`SCT_IDX_CNTH, 8'h12);
    rd(`SCT_IDX_STAT, 8'h02);
    settle(`SCT_IDX_STAT);
    rd(`SCT_IDX_CNTL, 8'h34);
    rd(`SCT_IDX_CNTH, 8'h12);
    rd(`SCT_IDX_TOPL, 8'h03);
    // tick bring-up in order, interval 4 steps, under standby
    sleep_standby <= 1'b1;
    wr(`SCT_IDX_TCTRL, 8'h08);
    settle(`SCT_IDX_TSTAT);
    wr(`SCT_IDX_TIRQEN, 8'h01);
    wr(`SCT_IDX_TCTRL, 8'h09);
    rd(`SCT_IDX_TSTAT, 8'h01);
    settle(`SCT_IDX_TSTAT);
    repeat (3200) @(posedge ref_clk);
    chk({16'h0, t7_gap}, 32'h200);
    chk({16'h0, t6_gap}, 32'h400);
    rd(`SCT_IDX_TPEND, 8'h01);
    chk({31'h0, tick_irq}, 32'h1);
    wr(`SCT_IDX_TIRQEN, 8'h00);
    repeat (3) @(posedge ref_clk);
    chk({31'h0, tick_irq}, 32'h0);
    wr(`SCT_IDX_TPEND, 8'h01);
    repeat (40) @(posedge ref_clk);
    rd(`SCT_IDX_TPEND, 8'h01);
    // switching the tick timer off stops new conditions
    wr(`SCT_IDX_TCTRL, 8'h08);
    settle(`SCT_IDX_TSTAT);
    wr(`SCT_IDX_TPEND, 8'h01);
    repeat (100) @(posedge ref_clk);
    rd(`SCT_IDX_TPEND, 8'h00);
    sleep_standby <= 1'b0;
    close_out();
  end
endmodule // tb_top
